// ---- rtl/clock_switch_pkg.sv ----
// Constants, field layout and carrier types for the dual loop clock switch.
// Overview of operation
// R1 - Hard reset clears writable config bits; primary loop runs from pins.
// R2 - Sampled ratio and range pins read back in config bits 0 to 6.
// R3 - Secondary loop uses register fields only; resets off, medium range.
// R4 - Select bit set moves core clock to secondary once the loop edges align.
// R5 - Status bit shows the active loop once each transition completes.
// R6 - Select bit cleared returns core clock to primary loop.
// R7 - Primary loop is off when its ratio is zero and internal control set.
// R8 - Software changes range and ratio only of the unselected loop.
// R9 - Software changes primary internal control only while unselected.
// R10 - Software selects a reconfigured loop only after its lock time.
// R11 - Software never selects a loop configured off.
// R12 - Never switch loops while both hold half-integer ratio codes.
// R13 - Half-integer to half-integer goes via integer ratio on the other loop.
// R14 - Mux select comes only from dedicated select logic, not the register.
// R15 - Select logic waits for both loop edges aligned with a reference edge.
// R16 - Mux select toggles only while both loop clocks are high.
// R17 - Target ratio above 2.5x suppresses exactly one core clock pulse.
// R18 - Fence passes reset values; scan shifting never reaches loop controls.
// R19 - Frequency change by hard reset holds reset while primary relocks.
// R20 - Deeper low-power modes wait until no bus operation is outstanding.
// R21 - A select written mid-switch acts only after that switch completes.
package clock_switch_pkg;

  // Register byte offsets on the Avalon slave.
  localparam logic [2:0] CLOCK_CONFIG_OFS = 3'h0;
  localparam logic [2:0] POWER_MODE_OFS = 3'h4;

  // Config register fields.
  localparam int PIN_RATIO_LSB = 0;
  localparam int PIN_RANGE_LSB = 5;
  localparam int ACTIVE_STATUS_BIT = 7;
  localparam int LOOP_SELECT_BIT = 8;
  localparam int PRIMARY_INT_BIT = 9;
  localparam int PRIMARY_RATIO_LSB = 10;
  localparam int PRIMARY_RANGE_LSB = 15;
  localparam int SECONDARY_RATIO_LSB = 17;
  localparam int SECONDARY_RANGE_LSB = 22;
  localparam int CONFIG_TOP_BIT = 23;

  // Power mode register fields.
  localparam int DOZE_BIT = 0;
  localparam int NAP_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int ARM_BIT = 3;

  // Reset values and the pulse block ratio threshold.
  localparam logic [4:0] RATIO_OFF = 5'h00;
  localparam logic [1:0] RANGE_MEDIUM = 2'h0;
  localparam logic [4:0] RATIO_2P5 = 5'h05;

  // Ratio codes count half steps: odd codes are half-integer ratios.
  typedef struct packed {
    logic off;
    logic [1:0] range;
    logic [4:0] ratio;
  } loop_ctrl_t;

  typedef enum {sw_idle, sw_align, sw_done} switch_state_t;

endpackage

// ---- rtl/dual_pll_clock_switch.sv ----
// Dual loop clock source control with glitch-free select and Avalon registers.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module dual_pll_clock_switch (
  // Clock and synchronous reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Strap pins for the primary loop.
  input wire logic [4:0] pin_ratio,
  input wire logic [1:0] pin_range,
  // Clock alignment observations, one cycle pulses and levels.
  input wire logic bus_ref_rise,
  input wire logic primary_rise,
  input wire logic secondary_rise,
  input wire logic primary_high,
  input wire logic secondary_high,
  // Scan shifting and bus quiescence.
  input wire logic scan_shift,
  input wire logic bus_idle,
  // Loop controls, mux select and pulse block.
  output clock_switch_pkg::loop_ctrl_t primary_ctrl,
  output clock_switch_pkg::loop_ctrl_t secondary_ctrl,
  output logic core_mux_sel,
  output logic pulse_block,
  // Power mode outputs.
  output logic doze_enter,
  output logic deep_mode_enter
);
  import clock_switch_pkg::*;

  logic [6:0] pins_q;
  logic loop_select_q;
  logic primary_int_q;
  logic [4:0] primary_ratio_q;
  logic [1:0] primary_range_q;
  logic [4:0] secondary_ratio_q;
  logic [1:0] secondary_range_q;
  logic [3:0] power_mode_q;
  logic status_q;
  logic mux_sel_q;
  logic block_q;
  logic target_q;
  logic wait_q;
  logic [31:0] readdata_q;
  logic doze_q;
  logic deep_q;
  loop_ctrl_t primary_ctrl_q;
  loop_ctrl_t secondary_ctrl_q;
  switch_state_t state_q;
  logic [31:0] config_word;
  logic access_done;
  logic aligned;
  loop_ctrl_t primary_eff;
  loop_ctrl_t secondary_eff;
  logic [4:0] target_ratio;
  logic [31:0] config_wr;
  logic [31:0] power_wr;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] new_w,
                                               input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // A write lands only at the edge where waitrequest is low.
  assign access_done = (read || write) && !wait_q;

  // Lanes merge over the current contents, so a partial write keeps the
  // bytes that were not enabled.
  assign config_wr = merge_bytes(config_word, writedata, byteenable);
  assign power_wr = merge_bytes({28'h000_0000, power_mode_q}, writedata,
                                byteenable);

  always_comb begin
    config_word = 32'h0000_0000;
    config_word[PIN_RATIO_LSB +: 5] = pins_q[4:0]; // R2
    config_word[PIN_RANGE_LSB +: 2] = pins_q[6:5]; // R2
    config_word[ACTIVE_STATUS_BIT] = status_q; // R5
    config_word[LOOP_SELECT_BIT] = loop_select_q;
    config_word[PRIMARY_INT_BIT] = primary_int_q;
    config_word[PRIMARY_RATIO_LSB +: 5] = primary_ratio_q;
    config_word[PRIMARY_RANGE_LSB +: 2] = primary_range_q;
    config_word[SECONDARY_RATIO_LSB +: 5] = secondary_ratio_q;
    config_word[SECONDARY_RANGE_LSB +: 2] = secondary_range_q;
  end

  // Straps are caught while hard reset is held, so a relock uses new pins.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pins_q <= {pin_range, pin_ratio}; // R19
    end
  end

  // Answer every access after one wait cycle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
    end else if ((read || write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      case (address)
        CLOCK_CONFIG_OFS: readdata_q <= config_word;
        POWER_MODE_OFS: readdata_q <= {28'h000_0000, power_mode_q};
        default: readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Config register: all writable bits clear at reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      loop_select_q <= 1'b0; // R1
      primary_int_q <= 1'b0; // R1
      primary_ratio_q <= RATIO_OFF; // R1
      primary_range_q <= RANGE_MEDIUM; // R1
      secondary_ratio_q <= RATIO_OFF; // R3
      secondary_range_q <= RANGE_MEDIUM; // R3
    end else if (access_done && write && address == CLOCK_CONFIG_OFS) begin
      loop_select_q <= config_wr[LOOP_SELECT_BIT];
      primary_int_q <= config_wr[PRIMARY_INT_BIT];
      primary_ratio_q <= config_wr[PRIMARY_RATIO_LSB +: 5];
      primary_range_q <= config_wr[PRIMARY_RANGE_LSB +: 2];
      secondary_ratio_q <= config_wr[SECONDARY_RATIO_LSB +: 5];
      secondary_range_q <= config_wr[SECONDARY_RANGE_LSB +: 2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      power_mode_q <= 4'h0;
    end else if (access_done && write && address == POWER_MODE_OFS) begin
      power_mode_q <= power_wr[3:0];
    end
  end

  // Effective loop settings before the fence.
  always_comb begin
    if (primary_int_q) begin
      primary_eff.ratio = primary_ratio_q;
      primary_eff.range = primary_range_q;
    end else begin
      primary_eff.ratio = pins_q[4:0]; // R1
      primary_eff.range = pins_q[6:5]; // R1
    end
    primary_eff.off = primary_int_q && primary_ratio_q == RATIO_OFF; // R7
    secondary_eff.ratio = secondary_ratio_q; // R3
    secondary_eff.range = secondary_range_q; // R3
    secondary_eff.off = secondary_ratio_q == RATIO_OFF; // R3
  end

  // The fence freezes loop controls while scan shifts the register chain.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      primary_ctrl_q <= '0; // R18
      secondary_ctrl_q <= '{off: 1'b1, range: RANGE_MEDIUM, ratio: RATIO_OFF};
    end else if (!scan_shift) begin
      primary_ctrl_q <= primary_eff; // R18
      secondary_ctrl_q <= secondary_eff; // R18
    end
  end

  // Both loops rise with the reference clock and both are high.
  assign aligned = bus_ref_rise && primary_rise && secondary_rise &&
                   primary_high && secondary_high; // R15 R16
  assign target_ratio = target_q ? secondary_ctrl_q.ratio
                                 : primary_ctrl_q.ratio;

  // Select state machine; the target is latched only when idle, so a new
  // select written mid-switch waits for the current switch to finish.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= sw_idle;
      target_q <= 1'b0;
    end else begin
      case (state_q)
        sw_idle: begin
          if (loop_select_q != mux_sel_q) begin // R21
            target_q <= loop_select_q; // R4 R6
            state_q <= sw_align;
          end
        end
        sw_align: begin
          if (aligned) begin
            state_q <= sw_done; // R15
          end
        end
        sw_done: state_q <= sw_idle;
        default: state_q <= sw_idle;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mux_sel_q <= 1'b0;
    end else if (state_q == sw_align && aligned) begin
      mux_sel_q <= target_q; // R14 R16
    end
  end

  // Fast target loops can out-run the old clock's last pulse, so one is
  // swallowed to keep a full-width pulse at the core.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else begin
      block_q <= state_q == sw_align && aligned &&
                 target_ratio > RATIO_2P5; // R17
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_q <= 1'b0;
    end else if (state_q == sw_done) begin
      status_q <= mux_sel_q; // R5
    end
  end

  // Deep modes wait until no Avalon access is in flight and the bus is idle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      doze_q <= 1'b0;
      deep_q <= 1'b0;
    end else begin
      doze_q <= power_mode_q[ARM_BIT] && power_mode_q[DOZE_BIT];
      deep_q <= power_mode_q[ARM_BIT] &&
                (power_mode_q[NAP_BIT] || power_mode_q[SLEEP_BIT]) &&
                bus_idle && !read && !write; // R20
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = wait_q;
  assign primary_ctrl = primary_ctrl_q;
  assign secondary_ctrl = secondary_ctrl_q;
  assign core_mux_sel = mux_sel_q;
  assign pulse_block = block_q;
  assign doze_enter = doze_q;
  assign deep_mode_enter = deep_q;

  // Assertions.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_reset_clears_select: assert property ( // R1
    $rose(reset_n) |-> !loop_select_q && !mux_sel_q && !status_q)
    else $error("select state not cleared by reset");

  a_pins_read_back: assert property ( // R2
    read && wait_q && address == CLOCK_CONFIG_OFS |=>
      readdata_q[6:0] == pins_q)
    else $error("pin bits wrong on readback");

  a_secondary_from_reg: assert property ( // R3
    !scan_shift |=> secondary_ctrl_q.ratio == $past(secondary_ratio_q))
    else $error("secondary loop not from register");

  a_switch_after_align: assert property ( // R4
    state_q == sw_align && aligned |=> mux_sel_q == $past(target_q)
      ##1 status_q == mux_sel_q)
    else $error("switch did not complete");

  a_status_tracks: assert property ( // R5
    state_q == sw_done |=> status_q == $past(mux_sel_q))
    else $error("status not updated after switch");

  a_primary_off: assert property ( // R7
    !scan_shift && primary_int_q && primary_ratio_q == RATIO_OFF |=>
      primary_ctrl_q.off)
    else $error("primary loop not off");

  a_mux_only_aligned: assert property ( // R16
    $changed(mux_sel_q) |-> $past(aligned) && $past(state_q == sw_align))
    else $error("mux changed without aligned high edges");

  a_one_pulse_block: assert property ( // R17
    block_q |=> !block_q)
    else $error("more than one pulse blocked");

  a_fence_holds: assert property ( // R18
    scan_shift ##1 scan_shift |-> $stable(primary_ctrl_q) &&
      $stable(secondary_ctrl_q))
    else $error("loop controls moved during scan");

  a_deep_quiet_bus: assert property ( // R20
    deep_q |-> $past(bus_idle) && !$past(read) && !$past(write))
    else $error("deep mode entered with bus busy");

  a_pending_select: assert property ( // R21
    state_q != sw_idle |=> $stable(target_q))
    else $error("target changed during switch");

  a_primary_from_pins: assert property ( // R1
    !scan_shift && !primary_int_q |=>
      primary_ctrl_q.ratio == $past(pins_q[4:0]) &&
      primary_ctrl_q.range == $past(pins_q[6:5]))
    else $error("primary loop not steered by pins");

  a_select_starts_switch: assert property ( // R4
    state_q == sw_idle && loop_select_q != mux_sel_q |=>
      state_q == sw_align && target_q == $past(loop_select_q))
    else $error("select write did not start a switch");

  a_back_to_primary: assert property ( // R6
    state_q == sw_align && aligned && !target_q |=> !mux_sel_q)
    else $error("mux did not return to primary loop");

  a_mux_waits_align: assert property ( // R14
    state_q != sw_align || !aligned |=> $stable(mux_sel_q))
    else $error("mux moved outside the select logic");

  a_block_with_switch: assert property ( // R17
    block_q |-> $changed(mux_sel_q) && $past(target_ratio) > RATIO_2P5)
    else $error("pulse blocked without a fast switch");

  a_fence_reset_values: assert property ( // R18
    $rose(reset_n) |-> primary_ctrl_q == '0 && secondary_ctrl_q.off)
    else $error("loop controls lost their reset values");

  c_to_secondary: cover property (state_q == sw_done && mux_sel_q);
  c_to_primary: cover property (state_q == sw_done && !mux_sel_q);
  c_pulse_blocked: cover property (block_q);
  c_deep_entry: cover property ($rose(deep_q));
  c_pending_select: cover property (state_q != sw_idle &&
                                    loop_select_q != target_q);

endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the dual loop clock switch.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import clock_switch_pkg::*;
  logic mclk, reset_n, read, write, waitrequest, core_mux_sel, pulse_block;
  logic bus_ref_rise, primary_rise, secondary_rise, primary_high;
  logic secondary_high, scan_shift, bus_idle, doze_enter, deep_mode_enter;
  logic [2:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [4:0] pin_ratio;
  logic [1:0] pin_range;
  loop_ctrl_t primary_ctrl, secondary_ctrl;
  int mismatches, compares;
  typedef struct packed {
    logic [2:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [1:0] p;
  } row_t;
  row_t rows [6];

  dual_pll_clock_switch dut (.mclk, .reset_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .pin_ratio,
    .pin_range, .bus_ref_rise, .primary_rise, .secondary_rise,
    .primary_high, .secondary_high, .scan_shift, .bus_idle,
    .primary_ctrl, .secondary_ctrl, .core_mux_sel, .pulse_block,
    .doze_enter, .deep_mode_enter);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task end_of_test;
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // The request stands until the rising edge that sees waitrequest low;
  // read data is taken at that same edge.
  task automatic acc(input logic [2:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge mclk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask

  // One cycle of edge observations; sh low keeps one loop clock low.
  task automatic align(input logic sh);
    @(posedge mclk);
    {bus_ref_rise, primary_rise, secondary_rise, primary_high} <= 4'hf;
    secondary_high <= sh;
    @(posedge mclk);
    {bus_ref_rise, primary_rise, secondary_rise} <= 3'h0;
    {primary_high, secondary_high} <= 2'h0;
    @(negedge mclk);
  endtask

  // Partial alignment must never move the mux; full alignment must.
  task automatic sw(input logic [31:0] cfg, input logic sel,
                    input logic pb);
    wr(3'h0, cfg);
    repeat (3) align(1'b0);
    chk(32'(core_mux_sel), 32'(!sel));
    align(1'b1);
    chk(32'(core_mux_sel), 32'(sel));
    chk(32'(pulse_block), 32'(pb));
    @(negedge mclk);
    chk(32'(pulse_block), 32'h0);
    rd(3'h0, {cfg[31:8], sel, cfg[6:0]});
  endtask

  task automatic rst(input logic [4:0] r, input logic [1:0] g);
    @(posedge mclk);
    reset_n <= 1'b0;
    pin_ratio <= r;
    pin_range <= g;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  initial begin
    reset_n = 1'b0;
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    pin_ratio = 5'h00;
    pin_range = 2'h0;
    {bus_ref_rise, primary_rise, secondary_rise} = 3'h0;
    {primary_high, secondary_high} = 2'h0;
    scan_shift = 1'b0;
    bus_idle = 1'b1;
    mismatches = 0;
    compares = 0;
    rows = '{'{3'h0, 32'h005000ff, 32'h00500024, 2'h0},
             '{3'h4, 32'h00000001, 32'h00000001, 2'h0},
             '{3'h4, 32'h00000009, 32'h00000009, 2'h2},
             '{3'h4, 32'h0000000a, 32'h0000000a, 2'h1},
             '{3'h4, 32'h0000000c, 32'h0000000c, 2'h1},
             '{3'h2, 32'hffffffff, 32'h00000000, 2'h1}};
    rst(5'h04, 2'h1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      repeat (2) @(negedge mclk);
      chk(32'({doze_enter, deep_mode_enter}), 32'(rows[i].p));
    end
    chk(32'(secondary_ctrl), 32'h28);
    // Deep modes wait for the system bus to go quiet.
    wr(3'h4, 32'h0000000a);
    bus_idle <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(32'(deep_mode_enter), 32'h0);
    @(posedge mclk);
    bus_idle <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(32'(deep_mode_enter), 32'h1);
    wr(3'h4, 32'h0);
    sw(32'h00500124, 1'b1, 1'b1);
    wr(3'h0, 32'h00500324);
    repeat (2) @(negedge mclk);
    chk(32'(primary_ctrl), 32'h80);
    wr(3'h0, 32'h00509b24);
    repeat (2) @(negedge mclk);
    chk(32'(primary_ctrl), 32'h26);
    @(posedge mclk);
    scan_shift <= 1'b1;
    wr(3'h0, 32'h00509324);
    repeat (2) @(negedge mclk);
    chk(32'(primary_ctrl), 32'h26);
    @(posedge mclk);
    scan_shift <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(32'(primary_ctrl), 32'h24);
    sw(32'h00509224, 1'b0, 1'b0);
    // A select written mid-switch waits for the running switch to end.
    wr(3'h0, 32'h00509324);
    wr(3'h0, 32'h00509224);
    align(1'b1);
    chk(32'(core_mux_sel), 32'h1);
    repeat (3) @(negedge mclk);
    align(1'b1);
    chk(32'(core_mux_sel), 32'h0);
    rd(3'h0, 32'h00509224);
    // A second hard reset mid-run with new strap values.
    rst(5'h06, 2'h2);
    chk(32'(primary_ctrl), 32'h46);
    chk(32'(secondary_ctrl), 32'h80);
    chk(32'(core_mux_sel), 32'h0);
    rd(3'h0, 32'h00000046);
    end_of_test();
  end
endmodule
`default_nettype wire
